// ===== rtl/rtk_pkg.sv
// Shared constants and types of the real-time clock timekeeping core
package rtk_pkg;
    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int OSC_RUN_EDGES = 32;
    localparam int OSC_FAIL_TIMEOUT_US = 200;
    localparam int OSC_FAIL_CYCLES = OSC_FAIL_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
    localparam int OSC_PRESCALE = 32768;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_SEC = 6'h00;
    localparam logic [5:0] IDX_MIN = 6'h01;
    localparam logic [5:0] IDX_HOUR = 6'h02;
    localparam logic [5:0] IDX_WEEKDAY = 6'h03;
    localparam logic [5:0] IDX_DATE = 6'h04;
    localparam logic [5:0] IDX_MONTH = 6'h05;
    localparam logic [5:0] IDX_YEAR = 6'h06;
    localparam logic [5:0] IDX_CTRL = 6'h07;
    localparam logic [5:0] IDX_SNAP_LAST = 6'h1F;

    // Field positions
    localparam int SEC_OSC_START_BIT = 7;
    localparam int HR_FMT12_BIT = 6;
    localparam int HR_PM_BIT = 5;
    localparam int WK_RUN_BIT = 5;
    localparam int MTH_LEAP_BIT = 5;
    localparam int CTRL_EXT_CLK_BIT = 3;

    // Writable bits
    localparam logic [7:0] MASK_SEC = 8'hFF;
    localparam logic [7:0] MASK_MIN = 8'h7F;
    localparam logic [7:0] MASK_HOUR = 8'h7F;
    localparam logic [7:0] MASK_WEEKDAY = 8'h07;
    localparam logic [7:0] MASK_DATE = 8'h3F;
    localparam logic [7:0] MASK_MONTH = 8'h1F;
    localparam logic [7:0] MASK_YEAR = 8'hFF;
    localparam logic [7:0] MASK_CTRL = 8'h08;

    // Reset values
    localparam logic [7:0] RST_SEC = 8'h00;
    localparam logic [7:0] RST_MIN = 8'h00;
    localparam logic [7:0] RST_HOUR = 8'h00;
    localparam logic [7:0] RST_WEEKDAY = 8'h01;
    localparam logic [7:0] RST_DATE = 8'h01;
    localparam logic [7:0] RST_MONTH = 8'h01;
    localparam logic [7:0] RST_YEAR = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;

    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } rtk_av_req_t;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] day_of_week_value;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] year;
    } rtk_time_t;
endpackage

// ===== rtl/rtk_core.sv
// Timekeeping core: oscillator monitor, BCD calendar and Avalon-MM register slave
module rtk_core #(
    parameter int PRESCALE = rtk_pkg::OSC_PRESCALE,
    parameter int FAIL_CYCLES = rtk_pkg::OSC_FAIL_CYCLES,
    parameter int RUN_EDGES = rtk_pkg::OSC_RUN_EDGES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register bus
    input wire rtk_pkg::rtk_av_req_t av_req,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Oscillator pin
    input wire logic osc_in,
    output logic osc_drive_en
);
    localparam int PW = $clog2(PRESCALE);
    localparam int FW = $clog2(FAIL_CYCLES + 1);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (PRESCALE < 2 || PRESCALE > 65536) begin : g_bad_prescale
        $error("PRESCALE out of range");
    end
    if (RUN_EDGES < 1 || RUN_EDGES > 63) begin : g_bad_run
        $error("RUN_EDGES out of range");
    end
    if (FAIL_CYCLES < 2) begin : g_bad_fail
        $error("FAIL_CYCLES too small");
    end

    rtk_pkg::rtk_time_t cur;
    rtk_pkg::rtk_time_t next_t;
    rtk_pkg::rtk_time_t live;
    rtk_pkg::rtk_time_t snap;
    rtk_pkg::rtk_time_t src;
    logic [7:0] ctrl;
    logic osc_s1, osc_s2, osc_s3;
    logic src_en, osc_edge, sec_tick;
    logic [PW-1:0] pre_cnt;
    logic [5:0] run_edges;
    logic [FW-1:0] idle_cnt;
    logic osc_running_flag;
    logic min_carry, hour_carry, day_carry, month_carry, year_carry;
    logic leap;
    logic [7:0] inc_tmp;
    logic [5:0] idx;
    logic req_wr, rd_start, snap_hit, refresh;
    logic seq_valid;
    logic [5:0] last_idx;
    logic [7:0] rd_byte;
    logic [7:0] wbyte;

    // ------------------------------------------------------------
    // BCD helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic is_leap(input logic [7:0] y);
        if (y[4])
            is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        else
            is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    endfunction

    function automatic logic [7:0] month_last(input logic [7:0] m, input logic lp);
        if (m == 8'h02)
            month_last = lp ? 8'h29 : 8'h28;
        else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11)
            month_last = 8'h30;
        else
            month_last = 8'h31;
    endfunction

    // ------------------------------------------------------------
    // Oscillator input
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
        end
        else
        begin
            osc_s1 <= osc_in;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
        end
    end

    assign src_en = cur.sec[rtk_pkg::SEC_OSC_START_BIT] | ctrl[rtk_pkg::CTRL_EXT_CLK_BIT];
    assign osc_edge = osc_s2 & ~osc_s3 & src_en;
    assign sec_tick = osc_edge && (pre_cnt == PW'(PRESCALE - 1));

    // crystal driver off in clock mode
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            osc_drive_en <= 1'b0;
        else
            osc_drive_en <= cur.sec[rtk_pkg::SEC_OSC_START_BIT] & ~ctrl[rtk_pkg::CTRL_EXT_CLK_BIT];
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            pre_cnt <= '0;
        else if (sec_tick)
            pre_cnt <= '0;
        else if (osc_edge)
            pre_cnt <= pre_cnt + PW'(1);
    end

    // ------------------------------------------------------------
    // Oscillator running flag
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_edges <= 6'h00;
            idle_cnt <= '0;
            osc_running_flag <= 1'b0;
        end
        else if (osc_edge)
        begin
            idle_cnt <= '0;
            if (run_edges == 6'(RUN_EDGES - 1))
                osc_running_flag <= 1'b1;
            else
                run_edges <= run_edges + 6'h01;
        end
        else if (idle_cnt == FW'(FAIL_CYCLES))
        begin
            osc_running_flag <= 1'b0;
            run_edges <= 6'h00;
        end
        else
            idle_cnt <= idle_cnt + FW'(1);
    end

    // ------------------------------------------------------------
    // Calendar carry chain
    // ------------------------------------------------------------
    always_comb
    begin
        next_t = cur;
        min_carry = 1'b0;
        hour_carry = 1'b0;
        day_carry = 1'b0;
        month_carry = 1'b0;
        year_carry = 1'b0;
        leap = is_leap(cur.year);
        inc_tmp = 8'h00;
        if (sec_tick)
        begin
            if (cur.sec[6:0] == 7'h59)
            begin
                next_t.sec[6:0] = 7'h00;
                min_carry = 1'b1;
            end
            else
            begin
                inc_tmp = bcd_inc({1'b0, cur.sec[6:0]});
                next_t.sec[6:0] = inc_tmp[6:0];
            end
        end
        if (min_carry)
        begin
            if (cur.min[6:0] == 7'h59)
            begin
                next_t.min = 8'h00;
                hour_carry = 1'b1;
            end
            else
                next_t.min = bcd_inc({1'b0, cur.min[6:0]});
        end
        if (hour_carry)
        begin
            if (cur.hour[rtk_pkg::HR_FMT12_BIT])
            begin
                if (cur.hour[4:0] == 5'h12)
                    next_t.hour = {1'b0, cur.hour[6:5], 5'h01};
                else if (cur.hour[4:0] == 5'h11)
                begin
                    next_t.hour = {1'b0, cur.hour[6], ~cur.hour[5], 5'h12};
                    day_carry = cur.hour[rtk_pkg::HR_PM_BIT];
                end
                else
                begin
                    inc_tmp = bcd_inc({3'b000, cur.hour[4:0]});
                    next_t.hour = {1'b0, cur.hour[6:5], inc_tmp[4:0]};
                end
            end
            else if (cur.hour[5:0] == 6'h23)
            begin
                next_t.hour = {1'b0, cur.hour[6], 6'h00};
                day_carry = 1'b1;
            end
            else
            begin
                inc_tmp = bcd_inc({2'b00, cur.hour[5:0]});
                next_t.hour = {1'b0, cur.hour[6], inc_tmp[5:0]};
            end
        end
        if (day_carry)
        begin
            if (cur.day_of_week_value[2:0] == 3'h7)
                next_t.day_of_week_value = 8'h01;
            else
                next_t.day_of_week_value = {5'h00, cur.day_of_week_value[2:0] + 3'h1};
            if (cur.date == month_last(cur.month, leap))
            begin
                next_t.date = 8'h01;
                month_carry = 1'b1;
            end
            else
                next_t.date = bcd_inc(cur.date);
        end
        if (month_carry)
        begin
            if (cur.month == 8'h12)
            begin
                next_t.month = 8'h01;
                year_carry = 1'b1;
            end
            else
                next_t.month = bcd_inc(cur.month);
        end
        if (year_carry)
            next_t.year = (cur.year == 8'h99) ? 8'h00 : bcd_inc(cur.year);
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign idx = av_req.address[7:2];
    assign wbyte = av_req.writedata[7:0];
    assign req_wr = av_req.write && !waitrequest;
    assign rd_start = av_req.read && waitrequest;
    assign snap_hit = rd_start && (idx <= rtk_pkg::IDX_SNAP_LAST);
    assign refresh = snap_hit && (!seq_valid || idx != last_idx + 6'h01 || idx == 6'h00);

    // ------------------------------------------------------------
    // Time and control registers
    // ------------------------------------------------------------
    // one counting path on any supply
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur <= {rtk_pkg::RST_SEC, rtk_pkg::RST_MIN, rtk_pkg::RST_HOUR, rtk_pkg::RST_WEEKDAY,
                    rtk_pkg::RST_DATE, rtk_pkg::RST_MONTH, rtk_pkg::RST_YEAR};
            ctrl <= rtk_pkg::RST_CTRL;
        end
        else
        begin
            cur <= next_t;
            if (req_wr)
            begin
                if (idx == rtk_pkg::IDX_SEC)
                    cur.sec <= wbyte & rtk_pkg::MASK_SEC;
                else if (idx == rtk_pkg::IDX_MIN)
                    cur.min <= wbyte & rtk_pkg::MASK_MIN;
                else if (idx == rtk_pkg::IDX_HOUR)
                    cur.hour <= wbyte & rtk_pkg::MASK_HOUR;
                else if (idx == rtk_pkg::IDX_WEEKDAY)
                    cur.day_of_week_value <= wbyte & rtk_pkg::MASK_WEEKDAY;
                else if (idx == rtk_pkg::IDX_DATE)
                    cur.date <= wbyte & rtk_pkg::MASK_DATE;
                else if (idx == rtk_pkg::IDX_MONTH)
                    cur.month <= wbyte & rtk_pkg::MASK_MONTH;
                else if (idx == rtk_pkg::IDX_YEAR)
                    cur.year <= wbyte & rtk_pkg::MASK_YEAR;
                else if (idx == rtk_pkg::IDX_CTRL)
                    ctrl <= wbyte & rtk_pkg::MASK_CTRL;
            end
        end
    end

    // ------------------------------------------------------------
    // Read view, snapshot and answer
    // ------------------------------------------------------------
    always_comb
    begin
        live = cur;
        live.day_of_week_value[rtk_pkg::WK_RUN_BIT] = osc_running_flag;
        live.month[rtk_pkg::MTH_LEAP_BIT] = leap;
        src = refresh ? live : snap;
        if (idx == rtk_pkg::IDX_SEC)
            rd_byte = src.sec;
        else if (idx == rtk_pkg::IDX_MIN)
            rd_byte = src.min;
        else if (idx == rtk_pkg::IDX_HOUR)
            rd_byte = src.hour;
        else if (idx == rtk_pkg::IDX_WEEKDAY)
            rd_byte = src.day_of_week_value;
        else if (idx == rtk_pkg::IDX_DATE)
            rd_byte = src.date;
        else if (idx == rtk_pkg::IDX_MONTH)
            rd_byte = src.month;
        else if (idx == rtk_pkg::IDX_YEAR)
            rd_byte = src.year;
        else if (idx == rtk_pkg::IDX_CTRL)
            rd_byte = ctrl;
        else
            rd_byte = 8'h00;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            snap <= '0;
        else if (refresh)
            snap <= live;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seq_valid <= 1'b0;
            last_idx <= 6'h00;
        end
        else if (snap_hit)
        begin
            seq_valid <= 1'b1;
            last_idx <= idx;
        end
        else if (rd_start || req_wr)
            seq_valid <= 1'b0;
    end

    // Every request is answered at the second edge
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
        end
        else
        begin
            waitrequest <= !((av_req.read || av_req.write) && waitrequest);
            if (rd_start)
                readdata <= {24'h00_0000, rd_byte};
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_run_set;
        @(posedge mclk) disable iff (!rst_n)
        osc_edge && run_edges == 6'(RUN_EDGES - 1) |=> osc_running_flag [*2];
    endproperty
    a_run_set: assert property (p_run_set) else $error("running flag not set");

    property p_run_clear;
        @(posedge mclk) disable iff (!rst_n)
        $fell(osc_running_flag) |-> $past(idle_cnt) == FW'(FAIL_CYCLES);
    endproperty
    a_run_clear: assert property (p_run_clear) else $error("flag cleared early");

    property p_stop_holds;
        @(posedge mclk) disable iff (!rst_n)
        !src_en |=> $stable(pre_cnt);
    endproperty
    a_stop_holds: assert property (p_stop_holds) else $error("prescaler ran");

    property p_sec_step;
        @(posedge mclk) disable iff (!rst_n)
        sec_tick && !req_wr |=> cur.sec != $past(cur.sec);
    endproperty
    a_sec_step: assert property (p_sec_step) else $error("seconds did not advance");

    property p_wk_wrap;
        @(posedge mclk) disable iff (!rst_n)
        day_carry && cur.day_of_week_value[2:0] == 3'h7 && !req_wr
        |=> cur.day_of_week_value == 8'h01;
    endproperty
    a_wk_wrap: assert property (p_wk_wrap) else $error("weekday wrap wrong");

    property p_year_wrap;
        @(posedge mclk) disable iff (!rst_n)
        year_carry && cur.year == 8'h99 && !req_wr |=> cur.year == 8'h00;
    endproperty
    a_year_wrap: assert property (p_year_wrap) else $error("year wrap wrong");

    property p_feb_end;
        @(posedge mclk) disable iff (!rst_n)
        day_carry && cur.month == 8'h02 && cur.date == 8'h28 && !leap && !req_wr
        |=> cur.date == 8'h01 && cur.month == 8'h03;
    endproperty
    a_feb_end: assert property (p_feb_end) else $error("February end wrong");

    property p_midnight;
        @(posedge mclk) disable iff (!rst_n)
        sec_tick && cur.sec[6:0] == 7'h59 && cur.min == 8'h59 && cur.hour == 8'h23 && !req_wr
        |=> cur.hour == 8'h00 && cur.date != $past(cur.date);
    endproperty
    a_midnight: assert property (p_midnight) else $error("midnight carry lost");

    property p_refresh;
        @(posedge mclk) disable iff (!rst_n)
        refresh |=> snap == $past(live);
    endproperty
    a_refresh: assert property (p_refresh) else $error("snapshot not refreshed");

    property p_answer;
        @(posedge mclk) disable iff (!rst_n)
        (av_req.read || av_req.write) && waitrequest |=> !waitrequest ##1 waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("answer timing wrong");
endmodule

// ===== verification/rtk_host_model.sv
// Host-side bus master model for the timekeeping core register bus
module rtk_host_model (
    // Clock and bus answer
    input wire logic mclk,
    input wire logic waitrequest,
    input wire logic [31:0] readdata,
    // Bus request
    output rtk_pkg::rtk_av_req_t av_req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial av_req = '0;

    // ------------------------------------------------------------
    // One transfer
    // ------------------------------------------------------------
    // Request holds until waitrequest is sampled low at an edge
    task automatic xfer(input logic [7:0] addr, input logic wr, input logic [7:0] wdat,
                        output logic [7:0] rdat);
        @(posedge mclk);
        av_req <= '{addr, ~wr, wr, {24'h000000, wdat}};
        do
            @(posedge mclk);
        while (waitrequest !== 1'b0);
        rdat = readdata[7:0];
        av_req <= '0;
    endtask
endmodule

// ===== verification/tb.sv
// Self-checking testbench of the timekeeping core
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic osc_in = 1'b0;
    rtk_pkg::rtk_av_req_t av_req;
    logic [31:0] readdata;
    logic waitrequest;
    logic osc_drive_en;
    logic [7:0] q;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;

    // Reset values, then per case: hours, weekday, date, month, year in and expected
    localparam logic [7:0] RST [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h21, 8'h00, 8'h00};
    localparam logic [7:0] HR_I [8] = '{8'h23, 8'h23, 8'h23, 8'h23, 8'h71, 8'h51, 8'h09, 8'h23};
    localparam logic [7:0] WK_I [8] = '{8'h07, 8'h03, 8'h03, 8'h01, 8'h02, 8'h02, 8'h02, 8'h02};
    localparam logic [7:0] DT_I [8] = '{8'h31, 8'h28, 8'h28, 8'h30, 8'h31, 8'h15, 8'h15, 8'h30};
    localparam logic [7:0] MO_I [8] = '{8'h12, 8'h02, 8'h02, 8'h04, 8'h01, 8'h05, 8'h05, 8'h01};
    localparam logic [7:0] YR_I [8] = '{8'h99, 8'h04, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05};
    localparam logic [7:0] HR_E [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h52, 8'h72, 8'h10, 8'h00};
    localparam logic [7:0] WK_E [8] = '{8'h01, 8'h04, 8'h04, 8'h02, 8'h03, 8'h02, 8'h02, 8'h03};
    localparam logic [7:0] DT_E [8] = '{8'h01, 8'h29, 8'h01, 8'h01, 8'h01, 8'h15, 8'h15, 8'h31};
    localparam logic [7:0] MO_E [8] = '{8'h21, 8'h22, 8'h03, 8'h05, 8'h02, 8'h05, 8'h05, 8'h01};
    localparam logic [7:0] YR_E [8] = '{8'h00, 8'h04, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05};

    always #4 mclk = ~mclk;

    // Oscillator source: period of 16 mclk, well inside the fail timeout
    always
    begin
        repeat (8) @(posedge mclk);
        osc_in <= ~osc_in;
    end

    rtk_core #(.PRESCALE(4), .FAIL_CYCLES(40), .RUN_EDGES(32)) i_dut (
        .mclk(mclk),
        .rst_n(rst_n),
        .av_req(av_req),
        .readdata(readdata),
        .waitrequest(waitrequest),
        .osc_in(osc_in),
        .osc_drive_en(osc_drive_en)
    );

    rtk_host_model i_host (
        .mclk(mclk),
        .waitrequest(waitrequest),
        .readdata(readdata),
        .av_req(av_req)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        if (mismatches == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        logic [7:0] x;
        i_host.xfer({i, 2'b00}, 1'b1, d, x);
    endtask

    task automatic rd(input logic [5:0] i, output logic [7:0] r);
        i_host.xfer({i, 2'b00}, 1'b0, 8'h00, r);
    endtask

    task automatic rdc(input logic [5:0] i, input logic [7:0] e);
        logic [7:0] x;
        rd(i, x);
        check(x, e);
        check(readdata[31:24] | readdata[23:16] | readdata[15:8], 8'h00);
    endtask

    task automatic wait_run(input logic v);
        int n;
        n = 0;
        do
        begin
            rd(6'h03, q);
            n++;
        end
        while (q[5] !== v && n < 300);
        check({7'h00, q[5]}, {7'h00, v});
    endtask

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        int n;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++)
            rdc(i[5:0], RST[i]);
        wr(6'h08, 8'h55);
        rdc(6'h08, 8'h00);
        wr(6'h01, 8'hD9);
        rdc(6'h01, 8'h59);
        wr(6'h02, 8'hD2);
        rdc(6'h02, 8'h52);
        for (int c = 0; c < 8; c++)
        begin
            wr(6'h00, 8'h59);
            wr(6'h01, 8'h59);
            wr(6'h02, HR_I[c]);
            wr(6'h03, WK_I[c]);
            wr(6'h04, DT_I[c]);
            wr(6'h05, MO_I[c]);
            wr(6'h06, YR_I[c]);
            wr(6'h00, 8'hD9);
            n = 0;
            do
            begin
                rd(6'h00, q);
                n++;
            end
            while (q !== 8'h80 && n < 300);
            check(q, 8'h80);
            // Whole set read in one ascending run from one snapshot
            rdc(6'h01, 8'h00);
            rdc(6'h02, HR_E[c]);
            rd(6'h03, q);
            check(q & 8'h07, WK_E[c]);
            rdc(6'h04, DT_E[c]);
            rdc(6'h05, MO_E[c]);
            rdc(6'h06, YR_E[c]);
            wr(6'h00, 8'h00);
            repeat (60) @(posedge mclk);
            wait_run(1'b0);
        end
        wr(6'h00, 8'h80);
        repeat (300) @(posedge mclk);
        wait_run(1'b0);
        wait_run(1'b1);
        check({7'h00, osc_drive_en}, 8'h01);
        wr(6'h00, 8'h00);
        wait_run(1'b0);
        rd(6'h00, q);
        repeat (200) @(posedge mclk);
        rdc(6'h00, q);
        wr(6'h07, 8'hFF);
        rdc(6'h07, 8'h08);
        repeat (200) @(posedge mclk);
        wait_run(1'b1);
        wr(6'h00, 8'h80);
        repeat (3) @(posedge mclk);
        check({7'h00, osc_drive_en}, 8'h00);
        wr(6'h07, 8'h00);
        repeat (3) @(posedge mclk);
        check({7'h00, osc_drive_en}, 8'h01);
        end_sim();
    end
endmodule
